// [verilog/sfl_pkg.sv]
// Shared constants for the serial flash status and write-latch logic
package sfl_pkg;

    // Opcodes
    localparam logic [7:0] OP_LATCH_SET     = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;
    localparam logic [7:0] OP_IDENT_READ    = 8'h9F;
    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_DUAL_ID_READ  = 8'hEF;
    localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG     = 8'h38;
    localparam logic [7:0] OP_CONT_PROG     = 8'hAD;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OP_HALF_BLK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE   = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hC7;

    // Status byte layout
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_PROT_LSB  = 2;
    localparam int ST_PROT_MSB  = 5;
    localparam int ST_QUAD_BIT  = 6;
    localparam int ST_LOCK_BIT  = 7;

    // Reset values
    localparam logic [3:0] PROT_RST  = 4'hF;
    localparam logic       QUAD_RST  = 1'b0;
    localparam logic       LOCK_RST  = 1'b0;
    localparam logic       LATCH_RST = 1'b0;

    // Frame geometry, in link clocks and bytes
    localparam logic [2:0] ADDR_CMD_BYTES = 3'h4;
    localparam logic [2:0] STATUS_WRITE_CMD_BYTES     = 3'h2;
    localparam logic [2:0] ID_BYTES       = 3'h3;
    localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
    localparam logic [5:0] DUAL_ADDR_LAST = 6'h13;

    // Self-timed cycle lengths
    localparam int CLK_PERIOD_NS        = 4;
    localparam int STATUS_WRITE_TIME_NS = 400;
    localparam int PROGRAM_TIME_NS      = 2000;
    localparam int ERASE_TIME_NS        = 8000;
    localparam int TIMER_W              = 12;
    localparam logic [TIMER_W-1:0] STATUS_WRITE_CYCLES =
        TIMER_W'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] PROGRAM_CYCLES =
        TIMER_W'((PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] ERASE_CYCLES =
        TIMER_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// [verilog/sfl_sync.sv]
// Two-flop synchroniser, one per bit, resets to zero
`timescale 1ns/100ps
module sfl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// [verilog/sfl_op_timer.sv]
// Countdown for self-timed program, erase and status-write cycles
`timescale 1ns/100ps
module sfl_op_timer (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          load,
    input  wire logic [sfl_pkg::TIMER_W-1:0]   cycles,
    output logic                               busy,
    output logic                               done
);

    logic [sfl_pkg::TIMER_W-1:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load && !busy) begin
                cnt_r <= cycles;
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_r <= sfl_pkg::TIMER_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_r <= cnt_r - sfl_pkg::TIMER_W'(1);
            end
        end
    end

endmodule

// [verilog/sfl_status_ctrl.sv]
// Serial flash command front end: write latch, status byte, identification readout
//
// Functional notes
// - Latch-set command sets the write latch when no cycle runs
// - Latch commands are one opcode byte only
// - Latch-clear command clears the write latch
// - Latch clears at reset and after changes
// - Identity read returns maker then two device bytes
// - Identity read ignored while a cycle runs
// - Status read works anytime, repeats while selected
// - Status bit 0 shows cycle in progress
// - Bit 1 is latch; clear latch refuses changes
// - Protected target ignored, latch kept
// - Bits 5:2 protection level, status write only
// - Chip erase needs low three levels zero
// - Protection level bits come up all ones
// - Bit 6 quad enable disables protect pin
// - Lock plus low protect pin blocks status write
// - Status lock comes up zero
// - Dual identity address selects first byte
// - Dual phases two bits per clock, lane1 high
// - Status write needs byte-aligned deselect, then timed
// - Locked status write rejected despite set latch
`timescale 1ns/100ps
module sfl_status_ctrl #(
    parameter logic [7:0]  MFR_CODE = 8'h5A,   // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'hA53C // Arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        link_clk,
    input  wire logic        cs_n,
    input  wire logic        io0_in,
    output logic             io0_out,
    output logic             io0_oe,
    input  wire logic        io1_in,
    output logic             io1_out,
    output logic             io1_oe,
    input  wire logic        wp_n,
    output logic [7:0]       status_byte,
    output logic             quad_io_enable,
    output logic             hardware_protect_state,
    output logic             array_start,
    output logic [7:0]       array_opcode,
    output logic [23:0]      array_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // Resets

    logic core_rst_n;
    logic link_rst_n;
    logic frame_rst_n;

    sfl_sync #(.W(1)) u_core_rst (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (core_rst_n)
    );

    sfl_sync #(.W(1)) u_link_rst (
        .clk   (link_clk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (link_rst_n)
    );

    // Deselect returns the link side to standby
    assign frame_rst_n = link_rst_n & ~cs_n;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: command capture on rising edges

    logic [5:0]  clk_cnt_r;
    logic [5:0]  clk_cnt_nxt;
    logic [2:0]  byte_cnt_r;
    logic [2:0]  byte_cnt_nxt;
    logic [7:0]  op_r;
    logic [7:0]  op_nxt;
    logic [7:0]  data_r;
    logic [7:0]  data_nxt;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic        addr_lsb_r;
    logic        addr_done_r;
    logic        id_ok_r;
    logic [7:0]  status_l;

    // Record of the last frame; frozen while the link clock stands
    logic        frame_tog_r;
    logic [7:0]  rec_op_r;
    logic [7:0]  rec_data_r;
    logic [23:0] rec_addr_r;
    logic [2:0]  rec_bytes_r;
    logic        rec_bound_r;

    sfl_sync #(.W(8)) u_status_sync (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .d     (status_byte),
        .q     (status_l)
    );

    always_comb begin
        clk_cnt_nxt  = clk_cnt_r + 6'd1;
        byte_cnt_nxt = byte_cnt_r;
        op_nxt       = op_r;
        data_nxt     = data_r;
        addr_nxt     = addr_r;
        if (clk_cnt_r[2:0] == 3'h7 && byte_cnt_r != sfl_pkg::BYTE_CNT_MAX) begin
            byte_cnt_nxt = byte_cnt_r + 3'd1;
        end
        if (byte_cnt_r == 3'd0) begin
            op_nxt = {op_r[6:0], io0_in};
        end
        if (byte_cnt_r == 3'd1) begin
            data_nxt = {data_r[6:0], io0_in};
        end
        if (byte_cnt_r != 3'd0 && byte_cnt_r < sfl_pkg::ADDR_CMD_BYTES) begin
            addr_nxt = {addr_r[22:0], io0_in};
        end
    end

    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            clk_cnt_r  <= '0;
            byte_cnt_r <= '0;
            op_r       <= '0;
            data_r     <= '0;
            addr_r     <= '0;
        end else begin
            clk_cnt_r  <= clk_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            op_r       <= op_nxt;
            data_r     <= data_nxt;
            addr_r     <= addr_nxt;
        end
    end

    // Identity read is decoded only when idle at opcode completion
    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            id_ok_r <= 1'b0;
        end else if (byte_cnt_r == 3'd0 && clk_cnt_r[2:0] == 3'h7) begin
            id_ok_r <= ~status_l[sfl_pkg::ST_BUSY_BIT];
        end
    end

    // Dual address: two bits a clock, lane1 carries the higher bit
    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            addr_lsb_r  <= 1'b0;
            addr_done_r <= 1'b0;
        end else if (op_r == sfl_pkg::OP_DUAL_ID_READ && !addr_done_r
                     && clk_cnt_r == sfl_pkg::DUAL_ADDR_LAST) begin
            addr_lsb_r  <= io0_in;
            addr_done_r <= 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_tog_r <= 1'b0;
            rec_op_r    <= '0;
            rec_data_r  <= '0;
            rec_addr_r  <= '0;
            rec_bytes_r <= '0;
            rec_bound_r <= 1'b0;
        end else begin
            if (clk_cnt_r == 6'd0 && byte_cnt_r == 3'd0) begin
                frame_tog_r <= ~frame_tog_r;
            end
            rec_op_r    <= op_nxt;
            rec_data_r  <= data_nxt;
            rec_addr_r  <= addr_nxt;
            rec_bytes_r <= byte_cnt_nxt;
            rec_bound_r <= (clk_cnt_nxt[2:0] == 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: answer shifted out on falling edges

    logic [7:0] sh_r;
    logic       oe_single_r;
    logic       oe_dual_r;
    logic [7:0] id_byte;

    always_comb begin
        unique case (byte_cnt_r)
            3'd1:    id_byte = MFR_CODE;
            3'd2:    id_byte = DEV_CODE[15:8];
            3'd3:    id_byte = DEV_CODE[7:0];
            default: id_byte = 8'h00;
        endcase
    end

    always_ff @(negedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sh_r        <= '0;
            oe_single_r <= 1'b0;
            oe_dual_r   <= 1'b0;
        end else if (byte_cnt_r != 3'd0) begin
            if (op_r == sfl_pkg::OP_STATUS_READ) begin
                oe_single_r <= 1'b1;
                if (clk_cnt_r[2:0] == 3'h0) begin
                    sh_r <= status_l;
                end else begin
                    sh_r <= {sh_r[6:0], 1'b0};
                end
            end else if (op_r == sfl_pkg::OP_IDENT_READ && id_ok_r) begin
                if (clk_cnt_r[2:0] == 3'h0) begin
                    oe_single_r <= (byte_cnt_r <= sfl_pkg::ID_BYTES);
                    sh_r        <= id_byte;
                end else begin
                    sh_r <= {sh_r[6:0], 1'b0};
                end
            end else if (op_r == sfl_pkg::OP_DUAL_ID_READ && addr_done_r) begin
                oe_dual_r <= 1'b1;
                if (clk_cnt_r[1:0] == 2'h0) begin
                    sh_r <= (~clk_cnt_r[2] ^ addr_lsb_r) ? DEV_CODE[7:0] : MFR_CODE;
                end else begin
                    sh_r <= {sh_r[5:0], 2'b00};
                end
            end
        end
    end

    assign io1_out = sh_r[7];
    assign io0_out = sh_r[6];
    assign io1_oe  = oe_single_r | oe_dual_r;
    assign io0_oe  = oe_dual_r;

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: frame end detection

    logic [2:0] pin_s;
    logic       cs_s;
    logic       wp_s;
    logic       tog_s;
    logic       cs_d_r;
    logic       tog_seen_r;
    logic       cmd_evt;

    // Record words are stable here: no link edges while deselected
    sfl_sync #(.W(3)) u_pin_sync (
        .clk   (core_clk),
        .rst_n (core_rst_n),
        .d     ({cs_n, wp_n, frame_tog_r}),
        .q     (pin_s)
    );

    assign cs_s  = pin_s[2];
    assign wp_s  = pin_s[1];
    assign tog_s = pin_s[0];

    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cs_d_r     <= 1'b0;
            tog_seen_r <= 1'b0;
        end else begin
            cs_d_r <= cs_s;
            if (cmd_evt) begin
                tog_seen_r <= tog_s;
            end
        end
    end

    // A frame with no link edges leaves the toggle alone and runs nothing
    assign cmd_evt = cs_s & ~cs_d_r & (tog_s ^ tog_seen_r);

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: command execution

    logic       latch_r;
    logic [3:0] prot_r;
    logic       quad_r;
    logic       lock_r;
    logic       busy;
    logic       op_done;
    logic       one_byte;
    logic       addr_ok;
    logic       area_prot;
    logic       latch_set_evt;
    logic       latch_clr_evt;
    logic       status_wr_evt;
    logic       array_evt;
    logic [sfl_pkg::TIMER_W-1:0] load_cycles;

    assign one_byte  = (rec_bytes_r == 3'd1) & rec_bound_r;
    assign addr_ok   = (rec_bytes_r >= sfl_pkg::ADDR_CMD_BYTES) & rec_bound_r;
    // Coarse area check: any nonzero level shields the whole array
    assign area_prot = (prot_r != 4'h0);
    assign hardware_protect_state = lock_r & ~wp_s & ~quad_r;

    always_comb begin
        latch_set_evt = 1'b0;
        latch_clr_evt = 1'b0;
        status_wr_evt = 1'b0;
        array_evt     = 1'b0;
        load_cycles   = sfl_pkg::PROGRAM_CYCLES;
        if (cmd_evt && rec_bytes_r != 3'd0) begin
            unique case (rec_op_r)
                sfl_pkg::OP_LATCH_SET: begin
                    latch_set_evt = one_byte & ~busy;
                end
                sfl_pkg::OP_LATCH_CLEAR: begin
                    latch_clr_evt = one_byte;
                end
                sfl_pkg::OP_STATUS_WRITE: begin
                    status_wr_evt = (rec_bytes_r >= sfl_pkg::STATUS_WRITE_CMD_BYTES) & rec_bound_r
                                    & latch_r & ~busy & ~hardware_protect_state;
                    load_cycles   = sfl_pkg::STATUS_WRITE_CYCLES;
                end
                sfl_pkg::OP_PAGE_PROG, sfl_pkg::OP_QUAD_PROG, sfl_pkg::OP_CONT_PROG: begin
                    array_evt = addr_ok & latch_r & ~busy & ~area_prot;
                end
                sfl_pkg::OP_SECTOR_ERASE, sfl_pkg::OP_HALF_BLK_ERASE,
                sfl_pkg::OP_BLOCK_ERASE: begin
                    array_evt   = addr_ok & latch_r & ~busy & ~area_prot;
                    load_cycles = sfl_pkg::ERASE_CYCLES;
                end
                sfl_pkg::OP_CHIP_ERASE_A, sfl_pkg::OP_CHIP_ERASE_B: begin
                    array_evt   = one_byte & latch_r & ~busy & (prot_r[2:0] == 3'h0);
                    load_cycles = sfl_pkg::ERASE_CYCLES;
                end
                default: begin
                end
            endcase
        end
    end

    sfl_op_timer u_timer (
        .clk    (core_clk),
        .rst_n  (core_rst_n),
        .load   (status_wr_evt | array_evt),
        .cycles (load_cycles),
        .busy   (busy),
        .done   (op_done)
    );

    // Set placed last so it wins over a same-cycle clear
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            latch_r <= sfl_pkg::LATCH_RST;
        end else begin
            if (op_done || latch_clr_evt) begin
                latch_r <= 1'b0;
            end
            if (latch_set_evt) begin
                latch_r <= 1'b1;
            end
        end
    end

    // New value takes effect as the timed cycle starts
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            prot_r <= sfl_pkg::PROT_RST;
            quad_r <= sfl_pkg::QUAD_RST;
            lock_r <= sfl_pkg::LOCK_RST;
        end else if (status_wr_evt) begin
            prot_r <= rec_data_r[sfl_pkg::ST_PROT_MSB:sfl_pkg::ST_PROT_LSB];
            quad_r <= rec_data_r[sfl_pkg::ST_QUAD_BIT];
            lock_r <= rec_data_r[sfl_pkg::ST_LOCK_BIT];
        end
    end

    // Hand-off to the array datapath
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            array_start  <= 1'b0;
            array_opcode <= '0;
            array_addr   <= '0;
        end else begin
            array_start <= array_evt;
            if (array_evt) begin
                array_opcode <= rec_op_r;
                array_addr   <= rec_addr_r;
            end
        end
    end

    always_comb begin
        status_byte = '0;
        status_byte[sfl_pkg::ST_BUSY_BIT]  = busy;
        status_byte[sfl_pkg::ST_LATCH_BIT] = latch_r;
        status_byte[sfl_pkg::ST_PROT_MSB:sfl_pkg::ST_PROT_LSB] = prot_r;
        status_byte[sfl_pkg::ST_QUAD_BIT]  = quad_r;
        status_byte[sfl_pkg::ST_LOCK_BIT]  = lock_r;
    end

    assign quad_io_enable = quad_r;

endmodule

// [tb/sfl_host_model.sv]
// Behavioural serial host for the flash front end
`timescale 1ns/100ps
module sfl_host_model (
    output logic      cs_n,
    output logic      link_clk,
    output logic      io0_drv,
    output logic      io1_drv,
    input  wire logic io0_w,
    input  wire logic io1_w
);
    initial begin
        cs_n = 1'b1;
        link_clk = 1'b0;
        io0_drv = 1'b0;
        io1_drv = 1'b1;
    end

    task automatic idle_clks(input int n);
        repeat (n) begin
            #7.5 link_clk = 1'b1;
            #7.5 link_clk = 1'b0;
        end
    endtask

    // One frame: nb bits out MSB first, then nr bits in; clock idles low
    task automatic xfer(input logic [31:0] tx, input int nb, input int nr, input bit dual,
                        output logic [31:0] rx);
        int p;
        bit rd;
        p = nb;
        rx = '0;
        cs_n = 1'b0;
        while (p > 0 || nr > 0) begin
            rd = (p == 0);
            if (rd) begin
                // Released lines toggle so stale data never looks valid
                io0_drv = ~io0_drv;
                io1_drv = ~io1_drv;
            end else if (dual && p <= nb - 8) begin
                io1_drv = tx[p-1];
                io0_drv = tx[p-2];
                p -= 2;
            end else begin
                io0_drv = tx[p-1];
                io1_drv = ~io1_drv;
                p--;
            end
            #7.5 link_clk = 1'b1;
            if (rd) begin
                rx = dual ? {rx[29:0], io1_w, io0_w} : {rx[30:0], io1_w};
                nr -= dual ? 2 : 1;
            end
            #7.5 link_clk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
    endtask
endmodule

// [tb/sfl_status_ctrl_asserts.sv]
// Port-level assertions for the flash front end
`timescale 1ns/100ps
module sfl_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       link_clk,
    input wire logic       cs_n,
    input wire logic       wp_n,
    input wire logic       io0_oe,
    input wire logic       io1_oe,
    input wire logic [7:0] status_byte,
    input wire logic       hardware_protect_state,
    input wire logic       array_start,
    input wire logic [7:0] array_opcode
);
    logic [11:0] bcnt_r;
    logic [5:0]  lcnt_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= 12'h000;
        end else begin
            bcnt_r <= status_byte[0] ? bcnt_r + 12'h001 : 12'h000;
        end
    end

    // Link rises within a frame; saturates so long reads cannot wrap
    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            lcnt_r <= 6'h00;
        end else if (lcnt_r != 6'h3F) begin
            lcnt_r <= lcnt_r + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////
    AST_START_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
        array_start |-> $past(status_byte[1]) && !$past(status_byte[0]) &&
        ($past(status_byte[5:2]) == 4'h0 || ($past(status_byte[4:2]) == 3'h0 &&
        array_opcode inside {8'h60, 8'hC7})))
        else $error("start not allowed");
    AST_BUSY_START: assert property (@(posedge core_clk) disable iff (!rst_n)
        array_start |-> ##[0:2] status_byte[0])
        else $error("no busy");
    AST_LATCH_END: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(status_byte[0]) |-> ##[0:1] !status_byte[1])
        else $error("latch kept");
    AST_PROT_STATUS_WRITE_CMD: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(status_byte[7:2]) |-> ##[0:2] status_byte[0])
        else $error("bits changed idle");
    AST_HW_PROT: assert property (@(posedge core_clk) disable iff (!rst_n)
        hardware_protect_state == (status_byte[7] && !status_byte[6] && !$past(wp_n, 2)))
        else $error("hw protect");
    AST_HPM_FROZEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        hardware_protect_state && $past(hardware_protect_state) |=> $stable(status_byte[7:2]))
        else $error("locked bits moved");
    AST_OE_DESEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        cs_n && $past(cs_n) |-> !io1_oe && !io0_oe)
        else $error("oe deselected");
    AST_OE_RISE: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(io1_oe) |-> lcnt_r == 6'h08 || lcnt_r == 6'h14)
        else $error("oe rise wrong");
    AST_ID_STOP: assert property (@(posedge link_clk) disable iff (!rst_n)
        $fell(io1_oe) && !cs_n && lcnt_r != 6'h00 |-> lcnt_r == 6'h20)
        else $error("id stop wrong");
    AST_BUSY_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(status_byte[0]) |-> bcnt_r inside {12'h064, 12'h1F4, 12'h7D0})
        else $error("cycle length");

    COV_START: cover property (@(posedge core_clk) array_start);
    COV_HPM: cover property (@(posedge core_clk) hardware_protect_state);
    COV_DONE: cover property (@(posedge core_clk) $fell(status_byte[0]));
endmodule

bind sfl_status_ctrl sfl_chk i_sfl_chk (
    .core_clk, .rst_n, .link_clk, .cs_n, .wp_n, .io0_oe, .io1_oe, .status_byte,
    .hardware_protect_state, .array_start, .array_opcode);

// [tb/tb_top.sv]
// Self-checking bench for the flash command front end
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0]  MFR = 8'h3A;    // Arbitrary value
    localparam logic [15:0] DEV = 16'h6B19; // Arbitrary value
    logic        core_clk;
    logic        rst_n;
    logic        wp_n;
    logic        cs_n;
    logic        link_clk;
    logic        io0_drv;
    logic        io1_drv;
    logic        io0_out;
    logic        io0_oe;
    logic        io1_out;
    logic        io1_oe;
    logic [7:0]  status_byte;
    logic        quad_en;
    logic        hw_prot;
    logic        array_start;
    logic [7:0]  array_opcode;
    logic [23:0] array_addr;
    wire logic   io0_w;
    wire logic   io1_w;
    logic [7:0]  es;
    logic [31:0] seed;
    logic [31:0] rx;
    int          error_cnt;
    int          checks_done;
    int          starts;

    assign io0_w = io0_oe ? io0_out : io0_drv;
    assign io1_w = io1_oe ? io1_out : io1_drv;

    sfl_status_ctrl #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_sfl_status_ctrl (
        .core_clk, .rst_n, .link_clk, .cs_n, .io0_in(io0_w), .io0_out, .io0_oe,
        .io1_in(io1_w), .io1_out, .io1_oe, .wp_n, .status_byte, .quad_io_enable(quad_en),
        .hardware_protect_state(hw_prot), .array_start, .array_opcode, .array_addr);
    sfl_host_model i_sfl_host_model (.cs_n, .link_clk, .io0_drv, .io1_drv, .io0_w, .io1_w);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (array_start === 1'b1) starts++;
    initial begin
        #380000;
        error_cnt++;
        $display("wrong value at %0t: run timed out", $time);
        final_report();
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic fr(input logic [31:0] tx, input int nb, input int nr, input bit dl,
                      output logic [31:0] rx);
        i_sfl_host_model.xfer(tx, nb, nr, dl, rx);
        repeat (6) @(posedge core_clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        fr({24'h0, op}, 8, 0, 1'b0, rx);
    endtask
    task automatic wsr(input logic [7:0] d, input int nb);
        fr({16'h0, 8'h01, d} << (nb - 16), nb, 0, 1'b0, rx);
    endtask
    task automatic st_chk(input logic [7:0] e);
        fr(32'h05, 8, 8, 1'b0, rx);
        chk(rx[7:0], e, "status");
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 200; n++) begin
            fr(32'h05, 8, 8, 1'b0, rx);
            if (rx[0] === 1'b0) return;
        end
        error_cnt++;
        $display("wrong value at %0t: busy never cleared", $time);
        final_report();
    endtask
    task automatic wsr_ok(input logic [7:0] d);
        cmd(8'h06);
        wsr(d, 16);
        es = {d[7:2], 2'b11};
        st_chk(es);
        wait_idle();
        es[1:0] = 2'b00;
        st_chk(es);
        chk(quad_en, es[6], "quad");
    endtask
    task automatic run_op(input logic [7:0] op, input bit acc);
        logic [23:0] a;
        bit          ce;
        int          n0;
        a = 24'(rnd());
        ce = (op == 8'h60 || op == 8'hC7);
        n0 = starts;
        cmd(8'h06);
        fr(ce ? {24'h0, op} : {op, a}, ce ? 8 : 32, 0, 1'b0, rx);
        chk(32'(starts - n0), 32'(acc), "start count");
        es[1:0] = {1'b1, acc};
        st_chk(es);
        if (acc) begin
            chk(array_opcode, op, "opcode");
            if (!ce) chk(array_addr, a, "address");
            wait_idle();
            es[1:0] = 2'b00;
            st_chk(es);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]  wq[3];
        logic [7:0]  ops[6];
        rst_n = 1'b0;
        wp_n = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        starts = 0;
        seed = 32'h0001_02C8;
        es = 8'h3C;
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
        i_sfl_host_model.idle_clks(4);
        repeat (6) @(posedge core_clk);
        st_chk(es);
        fr(32'h05, 8, 16, 1'b0, rx);
        chk(rx[15:0], {es, es}, "status repeat");
        fr(32'h9F, 8, 32, 1'b0, rx);
        chk(rx[31:8], {MFR, DEV}, "identity");
        for (int a = 0; a < 2; a++) begin
            fr({8'hEF, 24'(a)}, 32, 16, 1'b1, rx);
            chk(rx[15:0], a ? {DEV[7:0], MFR} : {MFR, DEV[7:0]}, "dual id");
        end
        fr(32'h03, 7, 0, 1'b0, rx);
        st_chk(es);
        cmd(8'h06);
        st_chk(8'h3E);
        cmd(8'h04);
        st_chk(8'h3C);
        wsr(8'h00, 16);
        st_chk(8'h3C);
        cmd(8'h06);
        wsr(8'h00, 20);
        st_chk(8'h3E);
        wq = '{8'(rnd()), 8'h40, 8'h00};
        foreach (wq[i]) wsr_ok(wq[i]);
        ops = '{8'h02, 8'h38, 8'hAD, 8'h20, 8'h52, 8'hD8};
        foreach (ops[i]) run_op(ops[i], 1'b1);
        wsr_ok(8'h20);
        run_op(8'hC7, 1'b1);
        wsr_ok(8'h04);
        run_op(8'h60, 1'b0);
        wsr_ok(8'h88);
        @(posedge core_clk);
        #1 wp_n = 1'b0;
        repeat (6) @(posedge core_clk);
        chk(hw_prot, 1'b1, "hw protect");
        cmd(8'h06);
        wsr(8'h00, 16);
        es = 8'h8A;
        st_chk(es);
        run_op(8'h02, 1'b0);
        @(posedge core_clk);
        #1 wp_n = 1'b1;
        repeat (6) @(posedge core_clk);
        wsr_ok(8'h00);
        final_report();
    end
endmodule
